// >>> logic/das_diag_alert.sv
`timescale 1ns/1ps
`include "das_diag_defs.svh"
module das_diag_alert #(
  parameter int EXPIRY_CYCLES = `DAS_EXPIRY_CYC
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic wb_cyc_in,
  input wire logic wb_stb_in,
  input wire logic wb_we_in,
  input wire logic [3:0] wb_adr_in,
  input wire logic [3:0] wb_sel_in,
  input wire logic [31:0] wb_dat_in,
  output logic [31:0] wb_dat_out,
  output logic wb_ack_out,
  input wire logic scan_done_in,
  input wire das_diag_pkg::das_result_s result_in,
  input wire logic result_valid_in,
  output logic scan_active_out,
  output logic selftest_run_out,
  output logic compacc_run_out,
  output logic irq_out
);
  // Scan completion and results come from an asynchronous acquisition engine
  logic [1:0] pin_async;
  logic [1:0] pin_mid;
  logic [1:0] pin_lvl;
  logic [1:0] pin_seen_r;
  logic [1:0] pin_seen_nxt;
  logic res_load;
  das_diag_pkg::das_result_s res_r;
  das_diag_pkg::das_result_s res_nxt;

  das_diag_pkg::das_scan_e state_r;
  das_diag_pkg::das_scan_e state_nxt;
  logic expiry_flag_r;
  logic expiry_flag_nxt;
  logic [3:0] alert_r;
  logic [3:0] alert_nxt;
  logic todis_r;
  logic todis_nxt;
  logic sten_r;
  logic sten_nxt;
  logic caen_r;
  logic caen_nxt;
  logic [2:0] scan_configuration_r;
  logic [2:0] scan_configuration_nxt;
  logic [4:0] irq_stat_r;
  logic [4:0] irq_stat_nxt;
  logic [4:0] irq_en_r;
  logic [4:0] irq_en_nxt;
  logic scan_active_nxt;
  logic selftest_run_nxt;
  logic compacc_run_nxt;
  logic irq_nxt;
  logic ack_nxt;
  logic [31:0] rdat_nxt;
  logic expired;
  logic done_evt;
  logic valid_evt;
  logic done_lvl;
  logic valid_lvl;
  logic wr_en;
  logic lo_wr;
  logic compacc_ok;
  logic [4:0] events;

  // Index 0 carries scan completion, index 1 result valid
  assign pin_async = {result_valid_in, scan_done_in};

  // Three stages per pin; a change counts once the last two agree
  for (genvar g = 0; g < 2; g++) begin : g_sync
    logic [2:0] sync_r;
    logic [2:0] sync_nxt;
    assign sync_nxt = {sync_r[1:0], pin_async[g]};
    assign pin_mid[g] = sync_r[1];
    assign pin_lvl[g] = (sync_r[2] == sync_r[1]) ? sync_r[1] : pin_seen_r[g];
    always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
        sync_r <= 3'h0;
      end else begin
        sync_r <= sync_nxt;
      end
    end
  end

  assign pin_seen_nxt = pin_lvl;
  assign done_lvl = pin_lvl[0];
  assign valid_lvl = pin_lvl[1];
  assign done_evt = done_lvl & ~pin_seen_r[0];
  assign valid_evt = valid_lvl & ~pin_seen_r[1];
  // Load one stage early so the counted valid edge already sees this acquisition
  assign res_load = pin_mid[1];

  // Results are held stable by the engine while valid is high
  always_comb begin
    res_nxt = res_r;
    if (res_load) begin
      res_nxt = result_in;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      pin_seen_r <= 2'h0;
      res_r <= '0;
    end else begin
      pin_seen_r <= pin_seen_nxt;
      res_r <= res_nxt;
    end
  end

  // Timer only runs while a scan is live and the expiry check is enabled
  das_scan_timer #(
    .CYCLES(EXPIRY_CYCLES)
  ) u_timer (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .run_in((state_r == das_diag_pkg::DAS_SCAN) & ~todis_r & ~expired),
    .expired_out(expired)
  );

  assign wr_en = wb_cyc_in & wb_stb_in & wb_we_in & ~wb_ack_out;
  assign lo_wr = wr_en & wb_sel_in[0];
  assign compacc_ok = caen_r & ((scan_configuration_r == `DAS_SCAN_CONFIGURATION_A) | (scan_configuration_r == `DAS_SCAN_CONFIGURATION_B));

  always_comb begin
    state_nxt = state_r;
    expiry_flag_nxt = expiry_flag_r;
    unique case (state_r)
      das_diag_pkg::DAS_IDLE: begin
        if (lo_wr & (wb_adr_in == `DAS_ADR_SCAN) & wb_dat_in[`DAS_SCAN_BIT_START]) begin
          state_nxt = das_diag_pkg::DAS_SCAN;
        end
      end
      das_diag_pkg::DAS_SCAN: begin
        if (expired & ~todis_r) begin
          state_nxt = das_diag_pkg::DAS_HALT;
          expiry_flag_nxt = 1'b1;
        end else if (done_evt) begin
          state_nxt = das_diag_pkg::DAS_IDLE;
        end
      end
      das_diag_pkg::DAS_HALT: begin
        if (~expiry_flag_r) begin
          state_nxt = das_diag_pkg::DAS_IDLE;
        end
      end
      default: state_nxt = das_diag_pkg::DAS_IDLE;
    endcase
    // Clearing the flag releases a halted scan; a new expiry in the same cycle wins
    if (lo_wr & (wb_adr_in == `DAS_ADR_SCAN) & ~wb_dat_in[`DAS_SCAN_BIT_FLAG]
        & ~(expired & ~todis_r & (state_r == das_diag_pkg::DAS_SCAN))) begin
      expiry_flag_nxt = 1'b0;
    end
  end

  always_comb begin
    alert_nxt = alert_r;
    // Write zero clears, write one is ignored, fresh fail wins over the clear
    if (lo_wr & (wb_adr_in == `DAS_ADR_ALERT)) begin
      alert_nxt = alert_r & wb_dat_in[3:0];
    end
    if (valid_evt & sten_r) begin
      alert_nxt[`DAS_BIT_LOW] = alert_nxt[`DAS_BIT_LOW] | res_r.low_fail;
      alert_nxt[`DAS_BIT_HIGH] = alert_nxt[`DAS_BIT_HIGH] | res_r.high_fail;
    end
    if (valid_evt & compacc_ok) begin
      alert_nxt[`DAS_BIT_OVER] = alert_nxt[`DAS_BIT_OVER] | res_r.over_fail;
      alert_nxt[`DAS_BIT_UNDER] = alert_nxt[`DAS_BIT_UNDER] | res_r.under_fail;
    end
  end

  always_comb begin
    todis_nxt = todis_r;
    sten_nxt = sten_r;
    caen_nxt = caen_r;
    scan_configuration_nxt = scan_configuration_r;
    irq_en_nxt = irq_en_r;
    if (lo_wr & (wb_adr_in == `DAS_ADR_CFG)) begin
      todis_nxt = wb_dat_in[`DAS_CFG_BIT_TODIS];
      sten_nxt = wb_dat_in[`DAS_CFG_BIT_STEN];
      caen_nxt = wb_dat_in[`DAS_CFG_BIT_CAEN];
      scan_configuration_nxt = wb_dat_in[`DAS_CFG_LSB_SCAN_CONFIGURATION +: 3];
    end
    if (lo_wr & (wb_adr_in == `DAS_ADR_IRQ_EN)) begin
      irq_en_nxt = wb_dat_in[`DAS_IRQ_BITS-1:0];
    end
  end

  assign events = {expiry_flag_nxt & ~expiry_flag_r, alert_nxt & ~alert_r};

  always_comb begin
    irq_stat_nxt = irq_stat_r;
    if (lo_wr & (wb_adr_in == `DAS_ADR_IRQ_CLR)) begin
      irq_stat_nxt = irq_stat_r & ~wb_dat_in[`DAS_IRQ_BITS-1:0];
    end
    irq_stat_nxt = irq_stat_nxt | events;
  end

  always_comb begin
    rdat_nxt = 32'h0000_0000;
    ack_nxt = wb_cyc_in & wb_stb_in & ~wb_ack_out;
    unique case (wb_adr_in)
      `DAS_ADR_ALERT: begin
        rdat_nxt[`DAS_BIT_EXPIRY] = expiry_flag_r;
        rdat_nxt[3:0] = alert_r;
      end
      `DAS_ADR_SCAN: begin
        rdat_nxt[`DAS_SCAN_BIT_FLAG] = expiry_flag_r;
        rdat_nxt[`DAS_SCAN_BIT_BUSY] = (state_r == das_diag_pkg::DAS_SCAN);
      end
      `DAS_ADR_CFG: begin
        rdat_nxt[`DAS_CFG_BIT_TODIS] = todis_r;
        rdat_nxt[`DAS_CFG_BIT_STEN] = sten_r;
        rdat_nxt[`DAS_CFG_BIT_CAEN] = caen_r;
        rdat_nxt[`DAS_CFG_LSB_SCAN_CONFIGURATION +: 3] = scan_configuration_r;
      end
      `DAS_ADR_IRQ_STAT: rdat_nxt[`DAS_IRQ_BITS-1:0] = irq_stat_r;
      `DAS_ADR_IRQ_EN: rdat_nxt[`DAS_IRQ_BITS-1:0] = irq_en_r;
      default: rdat_nxt = 32'h0000_0000;
    endcase
  end

  // Outputs follow the next state so each one leaves its own flip-flop
  always_comb begin
    scan_active_nxt = (state_nxt == das_diag_pkg::DAS_SCAN);
    selftest_run_nxt = sten_nxt & scan_active_nxt;
    compacc_run_nxt = scan_active_nxt & caen_nxt
      & ((scan_configuration_nxt == `DAS_SCAN_CONFIGURATION_A) | (scan_configuration_nxt == `DAS_SCAN_CONFIGURATION_B));
    irq_nxt = |(irq_stat_nxt & irq_en_nxt);
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      state_r <= das_diag_pkg::DAS_IDLE;
      expiry_flag_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      expiry_flag_r <= expiry_flag_nxt;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      alert_r <= 4'h0;
    end else begin
      alert_r <= alert_nxt;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      todis_r <= 1'b0;
      sten_r <= 1'b0;
      caen_r <= 1'b0;
      scan_configuration_r <= 3'h0;
      irq_en_r <= 5'h00;
    end else begin
      todis_r <= todis_nxt;
      sten_r <= sten_nxt;
      caen_r <= caen_nxt;
      scan_configuration_r <= scan_configuration_nxt;
      irq_en_r <= irq_en_nxt;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      irq_stat_r <= 5'h00;
    end else begin
      irq_stat_r <= irq_stat_nxt;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      wb_ack_out <= 1'b0;
      wb_dat_out <= 32'h0000_0000;
    end else begin
      wb_ack_out <= ack_nxt;
      wb_dat_out <= rdat_nxt;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      scan_active_out <= 1'b0;
      selftest_run_out <= 1'b0;
      compacc_run_out <= 1'b0;
      irq_out <= 1'b0;
    end else begin
      scan_active_out <= scan_active_nxt;
      selftest_run_out <= selftest_run_nxt;
      compacc_run_out <= compacc_run_nxt;
      irq_out <= irq_nxt;
    end
  end
endmodule : das_diag_alert

// >>> logic/das_diag_defs.svh
// Notes on behaviour
// - Bit 11 of the alert status always equals the scan expiry flag: 1 when a scan was halted by timeout.
// - A scan expiry fault halts the ongoing scan and sets the scan expiry flag to 1.
// - The scan expiry alert is enabled automatically whenever scan expiry disable is 0.
// - Bit 11 is read-only and clears only when software writes zero to the expiry flag in scan control.
// - Bit 3 reports the last zero-scale converter self-test result, 0 pass and 1 fail.
// - Bit 2 reports the last full-scale converter self-test result, 0 pass and 1 fail.
// - The converter self-tests run only while the shared self-test enable is set.
// - Bits 3..0 clear only on a written zero; a written one leaves them unchanged.
// - Bit 1 reports comparator accuracy over-voltage result; runs only for scan configuration 001 or 010 with enable 1.
// - Bit 0 reports comparator accuracy under-voltage result under the same conditions.
`ifndef DAS_DIAG_DEFS_SVH
`define DAS_DIAG_DEFS_SVH

`define DAS_ADR_ALERT 4'h0
`define DAS_ADR_SCAN 4'h1
`define DAS_ADR_CFG 4'h2
`define DAS_ADR_IRQ_STAT 4'h3
`define DAS_ADR_IRQ_EN 4'h4
`define DAS_ADR_IRQ_CLR 4'h5

`define DAS_BIT_EXPIRY 11
`define DAS_BIT_LOW 3
`define DAS_BIT_HIGH 2
`define DAS_BIT_OVER 1
`define DAS_BIT_UNDER 0

`define DAS_SCAN_BIT_START 0
`define DAS_SCAN_BIT_FLAG 1
`define DAS_SCAN_BIT_BUSY 2
`define DAS_CFG_BIT_TODIS 0
`define DAS_CFG_BIT_STEN 1
`define DAS_CFG_BIT_CAEN 2
`define DAS_CFG_LSB_SCAN_CONFIGURATION 4
`define DAS_SCAN_CONFIGURATION_A 3'h1
`define DAS_SCAN_CONFIGURATION_B 3'h2

`define DAS_EXPIRY_NS 1000
`define DAS_CLK_NS 10
`define DAS_EXPIRY_CYC (`DAS_EXPIRY_NS / `DAS_CLK_NS)

`define DAS_IRQ_BITS 5
`define DAS_ZERO16 16'h0000

`endif

// >>> logic/das_diag_pkg.sv
package das_diag_pkg;
  typedef struct packed {
    logic low_fail;
    logic high_fail;
    logic over_fail;
    logic under_fail;
  } das_result_s;

  typedef enum logic [1:0] {
    DAS_IDLE,
    DAS_SCAN,
    DAS_HALT
  } das_scan_e;
endpackage : das_diag_pkg

// >>> logic/das_scan_timer.sv
`timescale 1ns/1ps
`include "das_diag_defs.svh"
module das_scan_timer #(
  parameter int CYCLES = `DAS_EXPIRY_CYC
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic run_in,
  output logic expired_out
);
  logic [15:0] cnt_r;
  logic [15:0] cnt_nxt;
  logic expired_nxt;

  always_comb begin
    cnt_nxt = `DAS_ZERO16;
    expired_nxt = 1'b0;
    if (run_in) begin
      cnt_nxt = cnt_r + 16'h0001;
      expired_nxt = (cnt_r == 16'(CYCLES - 1));
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      cnt_r <= `DAS_ZERO16;
      expired_out <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      expired_out <= expired_nxt;
    end
  end
endmodule : das_scan_timer

// >>> bench/das_diag_props.sv
`timescale 1ns/1ps
module das_diag_props #(
  parameter int EXPIRY_CYCLES = 8
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic wb_cyc_in,
  input wire logic wb_stb_in,
  input wire logic wb_we_in,
  input wire logic [3:0] wb_adr_in,
  input wire logic [31:0] wb_dat_out,
  input wire logic wb_ack_out,
  input wire logic scan_active_out,
  input wire logic selftest_run_out,
  input wire logic compacc_run_out,
  input wire logic irq_out
);
  // Request not yet answered
  wire logic rq = wb_cyc_in & wb_stb_in & !wb_ack_out;
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  ack_after_req_a: assert property (rq |=> wb_ack_out) else $error("ack late");
  ack_one_cycle_a: assert property (wb_ack_out |=> !wb_ack_out) else $error("ack held");
  ack_no_req_a: assert property (!(wb_cyc_in && wb_stb_in) |=> !wb_ack_out)
    else $error("ack unasked");
  unmapped_zero_a: assert property (rq && !wb_we_in && wb_adr_in > 4'h5 |=> wb_dat_out == 32'h0)
    else $error("unmapped read not zero");
  alert_spare_a: assert property (
    rq && !wb_we_in && wb_adr_in == 4'h0 |=> wb_dat_out[31:12] == 20'h0 && wb_dat_out[10:4] == 7'h0)
    else $error("alert spare bits set");
  selftest_gate_a: assert property (selftest_run_out |-> scan_active_out)
    else $error("selftest outside scan");
  compacc_gate_a: assert property (compacc_run_out |-> scan_active_out)
    else $error("compacc outside scan");
  // Reset itself is the cause here, so the default disable is overridden
  reset_quiet_a: assert property (disable iff (1'b0)
    !rst_n_in |=> !irq_out && !scan_active_out && !wb_ack_out) else $error("busy after reset");
endmodule : das_diag_props

bind das_diag_alert das_diag_props #(.EXPIRY_CYCLES(EXPIRY_CYCLES)) das_diag_props_i (
  .clk_in(clk_in), .rst_n_in(rst_n_in), .wb_cyc_in(wb_cyc_in), .wb_stb_in(wb_stb_in),
  .wb_we_in(wb_we_in), .wb_adr_in(wb_adr_in), .wb_dat_out(wb_dat_out), .wb_ack_out(wb_ack_out),
  .scan_active_out(scan_active_out), .selftest_run_out(selftest_run_out),
  .compacc_run_out(compacc_run_out), .irq_out(irq_out));

// >>> bench/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  logic clk_in = 1'b0, rst_n_in = 1'b0, wb_cyc_in = 1'b0, wb_stb_in = 1'b0, wb_we_in = 1'b0;
  logic [3:0] wb_adr_in = 4'h0, r;
  logic [31:0] wb_dat_in = 32'h0, wb_dat_out, cfg, seed = 32'h8958bb9c;
  logic wb_ack_out, scan_done_in = 1'b0, result_valid_in = 1'b0, act, st, ca, irq_out;
  das_diag_pkg::das_result_s result_in = 4'h0;
  logic [63:0] exp_q[$];
  logic [63:0] ent;
  int fails = 0;
  int checked = 0;
  always #5 clk_in = ~clk_in;
  // Short expiry keeps each scan brief but longer than one acquisition
  das_diag_alert #(.EXPIRY_CYCLES(40)) das_diag_alert_i (.clk_in(clk_in), .rst_n_in(rst_n_in),
    .wb_cyc_in(wb_cyc_in), .wb_stb_in(wb_stb_in), .wb_we_in(wb_we_in), .wb_adr_in(wb_adr_in),
    .wb_sel_in(4'hf), .wb_dat_in(wb_dat_in), .wb_dat_out(wb_dat_out), .wb_ack_out(wb_ack_out),
    .scan_done_in(scan_done_in), .result_in(result_in), .result_valid_in(result_valid_in),
    .scan_active_out(act), .selftest_run_out(st), .compacc_run_out(ca), .irq_out(irq_out));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      fails++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask : cmp
  task automatic tally_and_finish;
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : tally_and_finish
  task automatic wt(input int n);
    repeat (n) @(posedge clk_in);
  endtask : wt
  // Reads carry a nonzero mask; writes push a zero mask and are not compared
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d, input logic [31:0] m);
    int n;
    exp_q.push_back({m, d & m});
    {wb_cyc_in, wb_stb_in, wb_we_in, wb_adr_in, wb_dat_in} <= {2'b11, w, a, d};
    n = 0;
    do begin
      @(posedge clk_in);
      n++;
    end while (wb_ack_out !== 1'b1 && n < 20);
    if (wb_ack_out !== 1'b1) begin
      fails++;
      tally_and_finish();
    end
    {wb_cyc_in, wb_stb_in} <= 2'b00;
    @(posedge clk_in);
  endtask : bus
  always @(posedge clk_in) begin
    if (wb_ack_out === 1'b1 && exp_q.size() > 0) begin
      ent = exp_q.pop_front();
      if (ent[63:32] != 32'h0) cmp("read data", ent[31:0], wb_dat_out & ent[63:32]);
    end
  end
  // Results first, then scan end; both levels are synchronised inside
  task automatic acq(input logic [3:0] v);
    result_in <= das_diag_pkg::das_result_s'(v);
    wt(1);
    result_valid_in <= 1'b1;
    wt(8);
    {result_valid_in, scan_done_in} <= 2'b01;
    wt(8);
    scan_done_in <= 1'b0;
    wt(2);
  endtask : acq
  initial begin
    wt(10);
    rst_n_in <= 1'b1;
    wt(1);
    bus(0, 4'h0, 32'h0, '1);
    bus(0, 4'h1, 32'h0, 32'h2);
    $display("test reset done");
    for (int c = 0; c < 8; c++) begin
      r = (c < 3) ? 4'hf : seed[3:0];
      seed = lfsr(seed);
      cfg = {25'h0, c[2:0], 4'h4} | {30'h0, c[0], 1'b0};
      bus(1, 4'h2, cfg, 32'h0);
      bus(1, 4'h1, 32'h1, 32'h0);
      cmp("scan active", 32'h1, {31'h0, act});
      cmp("selftest run", {31'h0, c[0]}, {31'h0, st});
      cmp("compacc run", {31'h0, (c == 1 || c == 2)}, {31'h0, ca});
      acq(r);
      bus(0, 4'h0, {28'h0, r & {{2{c[0]}}, {2{c == 1 || c == 2}}}}, '1);
      bus(1, 4'h0, 32'h0, 32'h0);
    end
    $display("test gating done");
    bus(1, 4'h2, 32'h16, 32'h0);
    bus(1, 4'h1, 32'h1, 32'h0);
    acq(4'hf);
    bus(1, 4'h0, 32'hffff, 32'h0);
    bus(0, 4'h0, 32'hf, '1);
    for (int k = 0; k < 4; k++) begin
      bus(1, 4'h0, ~(32'h1 << k), 32'h0);
      bus(0, 4'h0, (32'hf << (k + 1)) & 32'hf, '1);
    end
    $display("test clear done");
    bus(1, 4'h2, 32'h0, 32'h0);
    bus(1, 4'h1, 32'h1, 32'h0);
    wt(60);
    cmp("masked irq", 32'h0, {31'h0, irq_out});
    cmp("scan active", 32'h0, {31'h0, act});
    bus(1, 4'h4, 32'h10, 32'h0);
    wt(2);
    cmp("irq", 32'h1, {31'h0, irq_out});
    bus(0, 4'h3, 32'h1f, '1);
    bus(0, 4'h0, 32'h800, '1);
    bus(0, 4'h1, 32'h2, 32'h2);
    bus(1, 4'h0, 32'h0, 32'h0);
    bus(0, 4'h0, 32'h800, '1);
    bus(1, 4'h1, 32'h0, 32'h0);
    bus(0, 4'h0, 32'h0, '1);
    bus(1, 4'h5, 32'h1f, 32'h0);
    wt(2);
    cmp("cleared irq", 32'h0, {31'h0, irq_out});
    bus(0, 4'h3, 32'h0, '1);
    $display("test expiry done");
    bus(1, 4'h2, 32'h1, 32'h0);
    bus(1, 4'h1, 32'h1, 32'h0);
    wt(60);
    cmp("scan active", 32'h1, {31'h0, act});
    bus(0, 4'h0, 32'h0, '1);
    acq(4'h0);
    bus(1, 4'h9, 32'hffff, 32'h0);
    bus(0, 4'h9, 32'h0, '1);
    $display("test disable done");
    tally_and_finish();
  end
endmodule : tb_top
